// ### mdgr_host.sv
// Host model: register reads and writes on the request port
module mdgr_host
  import mdgr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in,
  output mdgr_req_s req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge sys_clk_in) req_out = '{1'b1, 1'b0, a, v};
    @(negedge sys_clk_in) req_out = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge sys_clk_in) req_out = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge sys_clk_in) req_out = '0;
    // Missing answer yields unknown so the compare fails
    v = rd_valid_in ? rd_data_in : 'x;
  endtask
endmodule

// ### mdgr_pkg.sv
// Package: offsets, field layouts, reset values and carriers of the monitor register bank
package mdgr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_ADC_RESULT_FIRST = 8'h23;
  localparam logic [7:0] ADDR_ADC_RESULT_LAST = 8'h32;
  localparam logic [7:0] ADDR_DAC_CODE_FIRST = 8'h33;
  localparam logic [7:0] ADDR_DAC_CODE_LAST = 8'h3e;
  localparam logic [7:0] ADDR_DAC_CLEAR_FIRST = 8'h3f;
  localparam logic [7:0] ADDR_DAC_CLEAR_LAST = 8'h4a;
  localparam logic [7:0] ADDR_OPEN_DRAIN_IO = 8'h4b;
  localparam logic [7:0] ADDR_DEVICE_CONFIG_ZERO = 8'h4c;

  // ----------------------------------------
  // Field layouts and widths
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int CODE_W = 12;
  localparam int IO_W = 8;
  localparam int ADC_CH = 16;
  localparam int DAC_CH = 12;
  localparam int CONV_DONE_BIT = 7;
  localparam int DIODE_ONE_LO_BIT = 4;
  localparam int DIODE_TWO_LO_BIT = 6;
  localparam logic [3:0] DIFF_PAIR_ZERO_ONE_CH = 4'h0;
  localparam logic [3:0] DIFF_PAIR_TWO_THREE_CH = 4'h2;
  // Writable config bits; 15:14, 8, 6, 5, 4 read zero, bit 7 is the flag
  localparam logic [15:0] CONFIG_ZERO_WMASK = 16'h3e0f;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CONFIG_ZERO_RESET = 16'h2000;
  localparam logic [11:0] DAC_CODE_RESET = 12'h000;
  localparam logic [11:0] DAC_CLEAR_RESET = 12'h000;
  localparam logic [11:0] ADC_RESULT_RESET = 12'h000;
  localparam logic [7:0] OPEN_DRAIN_IO_RESET = 8'hff;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mdgr_req_s;

  typedef struct packed {
    logic valid;
    logic diff;
    logic [3:0] chan;
    logic [11:0] code;
  } mdgr_conv_s;

endpackage

// ### mdgr_regs.sv
// Register bank: result, output code, clear value, open-drain I/O and config 0
// Notes on behaviour
// R1: Sixteen read-only results, upper four bits zero
// R2: Channel n result lands in result n
// R3: Single-ended straight binary; pairs 0/1, 2/3 twos complement
// R4: Twelve output code registers, reset zero, 12 bits
// R5: Clear-value registers loaded into latch on clear
// R6: I/O bit one releases pin, zero drives low
// R7: I/O read returns live pin levels
// R8: All I/O bits one after any reset
// R9: Diode one enabled ignores I/O bits 4, 5
// R10: Diode two enabled ignores I/O bits 6, 7
// R11: Config 0 resets 2000h, bits 15:14 zero
// R12: Diode enable inputs select ignored I/O pins
// R13: Result read, new start, or zero write clear flag
// R14: Result updated as one whole word
// R15: Writes to result registers have no effect
module mdgr_regs
  import mdgr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire mdgr_req_s req_in,
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  input wire mdgr_conv_s conv_in,
  input wire logic conv_start_in,
  input wire logic conv_done_in,
  input wire logic remote_diode_one_enable_in,
  input wire logic remote_diode_two_enable_in,
  input wire logic [11:0] dac_load_in,
  input wire logic [11:0] dac_clear_in,
  output logic [11:0][11:0] dac_latch_out,
  input wire logic [7:0] io_pin_in,
  output logic [7:0] io_pin_out,
  output logic [7:0] io_pin_oe_n_out,
  output logic conversion_done_flag_out
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [CODE_W-1:0] adc_result [ADC_CH];
  logic [CODE_W-1:0] dac_code [DAC_CH];
  logic [CODE_W-1:0] dac_clear_code [DAC_CH];
  logic [IO_W-1:0] open_drain_io;
  logic [DATA_W-1:0] device_config_zero;
  logic conversion_done_flag;
  logic [IO_W-1:0] pin_meta;
  logic [IO_W-1:0] pin_sync;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic hit_adc;
  logic hit_dac;
  logic hit_clr;
  logic [7:0] adc_off;
  logic [7:0] dac_off;
  logic [7:0] clr_off;
  logic [3:0] adc_idx;
  logic [3:0] dac_idx;
  logic [3:0] clr_idx;
  logic [IO_W-1:0] ignore_mask;
  logic [CODE_W-1:0] next_result;

  assign hit_adc = req_in.addr >= ADDR_ADC_RESULT_FIRST && req_in.addr <= ADDR_ADC_RESULT_LAST;
  assign hit_dac = req_in.addr >= ADDR_DAC_CODE_FIRST && req_in.addr <= ADDR_DAC_CODE_LAST;
  assign hit_clr = req_in.addr >= ADDR_DAC_CLEAR_FIRST && req_in.addr <= ADDR_DAC_CLEAR_LAST;
  assign adc_off = req_in.addr - ADDR_ADC_RESULT_FIRST;
  assign dac_off = req_in.addr - ADDR_DAC_CODE_FIRST;
  assign clr_off = req_in.addr - ADDR_DAC_CLEAR_FIRST;
  assign adc_idx = adc_off[3:0];
  assign dac_idx = dac_off[3:0];
  assign clr_idx = clr_off[3:0];

  // ----------------------------------------
  // Conversion results
  // ----------------------------------------
  always_comb begin
    next_result = conv_in.code;
    if (conv_in.diff && (conv_in.chan == DIFF_PAIR_ZERO_ONE_CH ||
        conv_in.chan == DIFF_PAIR_TWO_THREE_CH)) begin
      // Offset binary to twos complement [R3]
      next_result = {~conv_in.code[CODE_W-1], conv_in.code[CODE_W-2:0]};
    end
  end

  // Host writes never reach these [R15]
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < ADC_CH; i++) begin
        adc_result[i] <= ADC_RESULT_RESET;
      end
    end else if (conv_in.valid) begin
      adc_result[conv_in.chan] <= next_result; // [R2] [R14]
    end
  end

  // ----------------------------------------
  // Output code and clear-value registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < DAC_CH; i++) begin
        dac_code[i] <= DAC_CODE_RESET; // [R4]
        dac_clear_code[i] <= DAC_CLEAR_RESET; // [R5]
      end
    end else if (req_in.wr) begin
      if (hit_dac) begin
        dac_code[dac_idx] <= req_in.wdata[CODE_W-1:0]; // [R4]
      end
      if (hit_clr) begin
        dac_clear_code[clr_idx] <= req_in.wdata[CODE_W-1:0]; // [R5]
      end
    end
  end

  // Latch: clear wins over load
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < DAC_CH; i++) begin
        dac_latch_out[i] <= DAC_CODE_RESET;
      end
    end else begin
      for (int i = 0; i < DAC_CH; i++) begin
        if (dac_clear_in[i]) begin
          dac_latch_out[i] <= dac_clear_code[i]; // [R5]
        end else if (dac_load_in[i]) begin
          dac_latch_out[i] <= dac_code[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Open-drain I/O
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      open_drain_io <= OPEN_DRAIN_IO_RESET; // [R8]
    end else if (req_in.wr && req_in.addr == ADDR_OPEN_DRAIN_IO) begin
      open_drain_io <= req_in.wdata[IO_W-1:0];
    end
  end

  always_comb begin
    ignore_mask = '0;
    if (remote_diode_one_enable_in) begin
      ignore_mask[DIODE_ONE_LO_BIT +: 2] = 2'h3; // [R9] [R12]
    end
    if (remote_diode_two_enable_in) begin
      ignore_mask[DIODE_TWO_LO_BIT +: 2] = 2'h3; // [R10] [R12]
    end
  end

  assign io_pin_out = '0;
  assign io_pin_oe_n_out = open_drain_io | ignore_mask; // [R6] [R9] [R10]

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      // Idle level of the pulled-up pins, so no false low after reset
      pin_meta <= '1;
      pin_sync <= '1;
    end else begin
      pin_meta <= io_pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // Config 0 and conversion-done flag
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      device_config_zero <= CONFIG_ZERO_RESET; // [R11]
    end else if (req_in.wr && req_in.addr == ADDR_DEVICE_CONFIG_ZERO) begin
      device_config_zero <= req_in.wdata & CONFIG_ZERO_WMASK; // [R11]
    end
  end

  // Set wins over every clear
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_done_in) begin
      conversion_done_flag <= 1'b1;
    end else if (conv_start_in || (req_in.rd && hit_adc) ||
                 (req_in.wr && req_in.addr == ADDR_DEVICE_CONFIG_ZERO &&
                  !req_in.wdata[CONV_DONE_BIT])) begin
      conversion_done_flag <= 1'b0; // [R13]
    end
  end

  assign conversion_done_flag_out = conversion_done_flag;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= req_in.rd;
      rd_data_out <= '0;
      if (req_in.rd) begin
        if (hit_adc) begin
          rd_data_out <= {4'h0, adc_result[adc_idx]}; // [R1]
        end else if (hit_dac) begin
          rd_data_out <= {4'h0, dac_code[dac_idx]}; // [R4]
        end else if (hit_clr) begin
          rd_data_out <= {4'h0, dac_clear_code[clr_idx]};
        end else if (req_in.addr == ADDR_OPEN_DRAIN_IO) begin
          rd_data_out <= {8'h00, pin_sync}; // [R7]
        end else if (req_in.addr == ADDR_DEVICE_CONFIG_ZERO) begin
          rd_data_out <= device_config_zero |
                         (16'(conversion_done_flag) << CONV_DONE_BIT); // [R11]
        end
      end
    end
  end

endmodule

// ### mdgr_regs_bench.sv
// Bench: host access, conversions, latches and open-drain pins
module mdgr_regs_bench
  import mdgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cst = 1'b0, cdn = 1'b0, d1 = 1'b0, d2 = 1'b0, rdv, flg;
  logic [11:0] ld = '0, cl = '0;
  logic [11:0][11:0] lat;
  logic [7:0] ext = 8'hff, pin, oen;
  logic [15:0] rdd;
  mdgr_req_s req;
  mdgr_conv_s conv = '0;
  int num_errors = 0, checks_done = 0;
  // Pull-up on every pin
  assign pin = ext & oen;
  mdgr_regs dut (.sys_clk_in(clk), .srst_in(rst), .req_in(req), .rd_data_out(rdd),
    .rd_valid_out(rdv), .conv_in(conv), .conv_start_in(cst), .conv_done_in(cdn),
    .remote_diode_one_enable_in(d1), .remote_diode_two_enable_in(d2), .dac_load_in(ld),
    .dac_clear_in(cl), .dac_latch_out(lat), .io_pin_in(pin), .io_pin_out(),
    .io_pin_oe_n_out(oen), .conversion_done_flag_out(flg));
  mdgr_host host (.sys_clk_in(clk), .rd_data_in(rdd), .rd_valid_in(rdv), .req_out(req));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    host.rd(a, v);
    chk(v, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic cv(input int c, input logic df, input logic [11:0] v);
    @(negedge clk) conv = '{1'b1, df, 4'(c), v};
    @(negedge clk) conv = '0;
  endtask
  task automatic finish_test;
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (int a = 8'h33; a < 8'h4b; a++) rc(8'(a), 16'h0000);
    rc(8'h4b, 16'h00ff);
    rc(8'h4c, 16'h2000);
    host.wr(8'h33, 16'hffff);
    host.wr(8'h4a, 16'habcd);
    rc(8'h33, 16'h0fff);
    rc(8'h4a, 16'h0bcd);
    ld = 12'h001;
    cl = 12'h800;
    @(negedge clk);
    ld = '0;
    cl = '0;
    chk({4'h0, lat[0]}, 16'h0fff);
    chk({4'h0, lat[11]}, 16'h0bcd);
    ld = 12'h001;
    cl = 12'h001;
    @(negedge clk);
    ld = '0;
    cl = '0;
    chk({4'h0, lat[0]}, 16'h0000);
    for (int c = 0; c < 16; c++) cv(c, 1'b0, {3{4'(c)}});
    for (int c = 0; c < 16; c++) rc(8'h23 + 8'(c), {4'h0, {3{4'(c)}}});
    cv(0, 1'b1, 12'h800);
    cv(2, 1'b1, 12'h7ff);
    cv(5, 1'b1, 12'h123);
    rc(8'h25, 16'h0fff);
    rc(8'h28, 16'h0123);
    host.wr(8'h24, 16'hffff);
    rc(8'h24, 16'h0111);
    pulse(cdn);
    rc(8'h4c, 16'h2080);
    rc(8'h23, 16'h0000);
    chk({15'h0, flg}, 16'h0000);
    pulse(cdn);
    pulse(cst);
    chk({15'h0, flg}, 16'h0000);
    pulse(cdn);
    host.wr(8'h4c, 16'hffff);
    rc(8'h4c, 16'h3e8f);
    host.wr(8'h4c, 16'h0000);
    chk({15'h0, flg}, 16'h0000);
    host.wr(8'h4b, 16'h000f);
    chk({8'h00, oen}, 16'h000f);
    ext = 8'h0e;
    repeat (3) @(negedge clk);
    rc(8'h4b, 16'h000e);
    d1 = 1'b1;
    #1 chk({8'h00, oen}, 16'h003f);
    d2 = 1'b1;
    #1 chk({8'h00, oen}, 16'h00ff);
    finish_test;
  end
endmodule
bind mdgr_regs mdgr_regs_chk chk_i (.*);

// ### mdgr_regs_chk.sv
// Checker of the monitor register bank ports
module mdgr_regs_chk
  import mdgr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire mdgr_req_s req_in,
  input wire logic [15:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic conv_start_in,
  input wire logic conv_done_in,
  input wire logic remote_diode_one_enable_in,
  input wire logic remote_diode_two_enable_in,
  input wire logic [7:0] io_pin_out,
  input wire logic [7:0] io_pin_oe_n_out,
  input wire logic conversion_done_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_res_rd;
    req_in.rd && req_in.addr inside {[ADDR_ADC_RESULT_FIRST:ADDR_ADC_RESULT_LAST]};
  endsequence
  property p_rv; req_in.rd |=> rd_valid_out; endproperty
  a_rv: assert property (p_rv) else $error("read unanswered");
  property p_hi; s_res_rd |=> rd_data_out[15:12] == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_od; io_pin_out == 8'h00; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_d1; remote_diode_one_enable_in |-> &io_pin_oe_n_out[5:4]; endproperty
  a_d1: assert property (p_d1) else $error("diode one pins driven");
  property p_d2; remote_diode_two_enable_in |-> &io_pin_oe_n_out[7:6]; endproperty
  a_d2: assert property (p_d2) else $error("diode two pins driven");
  property p_fs; conv_done_in |=> conversion_done_flag_out; endproperty
  a_fs: assert property (p_fs) else $error("flag not set");
  property p_fr; s_res_rd ##0 !conv_done_in |=> !conversion_done_flag_out; endproperty
  a_fr: assert property (p_fr) else $error("flag kept on read");
  property p_fc; conv_start_in && !conv_done_in |=> !conversion_done_flag_out; endproperty
  a_fc: assert property (p_fc) else $error("flag kept on start");
endmodule
